// file: core/aai_core.sv
// Four-phase execution of literal and register add/AND instructions
`timescale 1ns/1ps
module aai_core (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [aai_pkg::WORD_W-1:0] instr_in,
	input wire logic [aai_pkg::ADDR_W-1:0] port_addr_in,
	input wire logic [aai_pkg::DATA_W-1:0] port_pins_in,
	output logic [aai_pkg::DATA_W-1:0] acc_out,
	output aai_pkg::aai_flags_type flags_out,
	output aai_pkg::aai_phase_type phase_out,
	output logic done_out,
	output logic mem_we_out,
	output logic [aai_pkg::ADDR_W-1:0] mem_addr_out,
	output logic [aai_pkg::DATA_W-1:0] mem_data_out
);
	////////////////////////////////////////////////////////////////////////////////
	aai_pkg::aai_state_type state;
	aai_pkg::aai_state_type next_state;
	aai_pkg::aai_alu_out_type alu_res;
	logic [aai_pkg::DATA_W-1:0] ram [aai_pkg::DEPTH];
	logic [aai_pkg::DATA_W-1:0] pin_s1;
	logic [aai_pkg::DATA_W-1:0] pin_s2;
	logic [aai_pkg::DATA_W-1:0] pin_s3;
	logic [aai_pkg::DATA_W-1:0] pin_level;
	logic [5:0] top;
	logic is_add;

	// Pins are asynchronous: three stages, accepted when last two agree
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pin_s1 <= aai_pkg::ZERO_BYTE;
			pin_s2 <= aai_pkg::ZERO_BYTE;
			pin_s3 <= aai_pkg::ZERO_BYTE;
			pin_level <= aai_pkg::ZERO_BYTE;
		end else begin
			pin_s1 <= port_pins_in;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			if (pin_s2 == pin_s3) begin
				pin_level <= pin_s3;
			end
		end
	end

	assign top = instr_in[aai_pkg::OP_HI:aai_pkg::OP_LO];
	assign is_add = (state.op == aai_pkg::OPK_ADD_LIT) || (state.op == aai_pkg::OPK_ADD_REG);

	aai_alu u_alu (
		.acc_in(state.acc),
		.operand_in(state.operand),
		.is_add_in(is_add),
		.flags_in(state.flags),
		.alu_out(alu_res)
	);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		next_state.mem_we = 1'b0;
		next_state.done = 1'b0;
		unique case (state.phase)
			aai_pkg::PH_DECODE: begin
				next_state.phase = aai_pkg::PH_READ;
				next_state.addr = instr_in[aai_pkg::ADDR_W-1:0];
				next_state.dest_reg = instr_in[aai_pkg::DEST_BIT];
				next_state.operand = instr_in[aai_pkg::DATA_W-1:0];
				if ((top & aai_pkg::OP_ADD_LIT_MASK) == aai_pkg::OP_ADD_LIT) begin
					next_state.op = aai_pkg::OPK_ADD_LIT;
				end else if (top == aai_pkg::OP_AND_LIT) begin
					next_state.op = aai_pkg::OPK_AND_LIT;
				end else if (top == aai_pkg::OP_ADD_REG) begin
					next_state.op = aai_pkg::OPK_ADD_REG;
				end else if (top == aai_pkg::OP_AND_REG) begin
					next_state.op = aai_pkg::OPK_AND_REG;
				end else begin
					// Other opcodes belong to the rest of the core
					next_state.op = aai_pkg::OPK_NONE;
				end
			end
			aai_pkg::PH_READ: begin
				next_state.phase = aai_pkg::PH_PROCESS;
				if (state.op == aai_pkg::OPK_ADD_REG || state.op == aai_pkg::OPK_AND_REG) begin
					if (state.addr == port_addr_in) begin
						next_state.operand = pin_level;
					end else begin
						next_state.operand = ram[state.addr];
					end
				end
			end
			aai_pkg::PH_PROCESS: begin
				next_state.phase = aai_pkg::PH_WRITE;
				next_state.alu = alu_res;
			end
			aai_pkg::PH_WRITE: begin
				next_state.phase = aai_pkg::PH_DECODE;
				if (state.op != aai_pkg::OPK_NONE) begin
					next_state.flags = state.alu.flags;
					next_state.done = 1'b1;
					if ((state.op == aai_pkg::OPK_ADD_REG || state.op == aai_pkg::OPK_AND_REG)
						&& state.dest_reg) begin
						next_state.mem_we = 1'b1;
						next_state.mem_addr = state.addr;
						next_state.mem_data = state.alu.result;
					end else begin
						next_state.acc = state.alu.result;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= '{phase: aai_pkg::PH_DECODE, op: aai_pkg::OPK_NONE, dest_reg: 1'b0,
				addr: aai_pkg::ZERO_ADDR, operand: aai_pkg::ZERO_BYTE,
				alu: '{result: aai_pkg::ZERO_BYTE, flags: '{1'b0, 1'b0, 1'b0}},
				acc: aai_pkg::ZERO_BYTE, flags: '{1'b0, 1'b0, 1'b0}, mem_we: 1'b0,
				mem_addr: aai_pkg::ZERO_ADDR, mem_data: aai_pkg::ZERO_BYTE, done: 1'b0};
		end else begin
			state <= next_state;
		end
	end

	// Register file has no reset; contents are undefined until written
	always_ff @(posedge clk_in) begin
		if (next_state.mem_we) begin
			ram[next_state.mem_addr] <= next_state.mem_data;
		end
	end

	assign acc_out = state.acc;
	assign flags_out = state.flags;
	assign phase_out = state.phase;
	assign done_out = state.done;
	assign mem_we_out = state.mem_we;
	assign mem_addr_out = state.mem_addr;
	assign mem_data_out = state.mem_data;

	////////////////////////////////////////////////////////////////////////////////
	// Sampled reset in the antecedent: the release edge itself does not advance the phase
	sequence foreign_op_taken;
		reset_n_in && state.phase == aai_pkg::PH_DECODE &&
		(top & aai_pkg::OP_ADD_LIT_MASK) != aai_pkg::OP_ADD_LIT &&
		top != aai_pkg::OP_AND_LIT && top != aai_pkg::OP_ADD_REG && top != aai_pkg::OP_AND_REG;
	endsequence

	phase_order_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		reset_n_in && state.phase == aai_pkg::PH_DECODE |=> state.phase == aai_pkg::PH_READ ##1
		state.phase == aai_pkg::PH_PROCESS ##1 state.phase == aai_pkg::PH_WRITE)
		else $error("phase order broken");

	add_lit_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state.phase == aai_pkg::PH_DECODE &&
		(top & aai_pkg::OP_ADD_LIT_MASK) == aai_pkg::OP_ADD_LIT
		|-> ##4 acc_out == $past(state.acc, 4) + $past(instr_in[aai_pkg::DATA_W-1:0], 4) &&
		done_out)
		else $error("literal add result wrong");

	and_lit_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state.phase == aai_pkg::PH_DECODE && top == aai_pkg::OP_AND_LIT
		|-> ##4 acc_out == ($past(state.acc, 4) & $past(instr_in[aai_pkg::DATA_W-1:0], 4)) &&
		flags_out.carry == $past(state.flags.carry, 4) &&
		flags_out.half_carry == $past(state.flags.half_carry, 4))
		else $error("literal and result or flags wrong");

	and_reg_flags_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state.phase == aai_pkg::PH_DECODE && top == aai_pkg::OP_AND_REG
		|-> ##4 flags_out.carry == $past(state.flags.carry, 4))
		else $error("register and touched carry");

	dest_reg_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state.phase == aai_pkg::PH_DECODE && (top == aai_pkg::OP_ADD_REG ||
		top == aai_pkg::OP_AND_REG) && instr_in[aai_pkg::DEST_BIT]
		|-> ##4 mem_we_out && mem_addr_out == $past(instr_in[aai_pkg::ADDR_W-1:0], 4) &&
		acc_out == $past(acc_out))
		else $error("register destination not written");

	dest_acc_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state.phase == aai_pkg::PH_DECODE && top == aai_pkg::OP_ADD_REG &&
		!instr_in[aai_pkg::DEST_BIT] |-> ##4 !mem_we_out && done_out)
		else $error("accumulator destination wrote memory");

	zero_flag_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		done_out |-> flags_out.zero == ($past(state.alu.result) == aai_pkg::ZERO_BYTE))
		else $error("zero flag mismatch");

	port_read_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state.phase == aai_pkg::PH_READ && state.addr == port_addr_in &&
		(state.op == aai_pkg::OPK_ADD_REG || state.op == aai_pkg::OPK_AND_REG)
		|=> state.operand == $past(pin_level))
		else $error("port operand not from pins");

	idle_quiet_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		foreign_op_taken |-> ##4 !done_out && !mem_we_out &&
		acc_out == $past(acc_out, 4) && flags_out == $past(flags_out, 4))
		else $error("unknown opcode changed state");
endmodule : aai_core

// file: core/aai_pkg.sv
// Package: opcodes, phases, flag layout and state types for the add/and execution unit
package aai_pkg;
	localparam int WORD_W = 14;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int DEPTH = 128;
	// Opcode top six bits
	localparam logic [5:0] OP_ADD_LIT = 6'h3e;
	localparam logic [5:0] OP_ADD_LIT_MASK = 6'h3e;
	localparam logic [5:0] OP_AND_LIT = 6'h39;
	localparam logic [5:0] OP_ADD_REG = 6'h07;
	localparam logic [5:0] OP_AND_REG = 6'h05;
	localparam int OP_HI = 13;
	localparam int OP_LO = 8;
	localparam int DEST_BIT = 7;
	localparam int HALF_W = 4;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [ADDR_W-1:0] ZERO_ADDR = 7'h00;
	localparam logic [WORD_W-1:0] ZERO_WORD = 14'h0000;

	typedef enum logic [1:0] {
		PH_DECODE = 2'b00,
		PH_READ = 2'b01,
		PH_PROCESS = 2'b10,
		PH_WRITE = 2'b11
	} aai_phase_type;

	typedef enum logic [2:0] {
		OPK_NONE = 3'b000,
		OPK_ADD_LIT = 3'b001,
		OPK_AND_LIT = 3'b010,
		OPK_ADD_REG = 3'b011,
		OPK_AND_REG = 3'b100
	} aai_op_type;

	typedef struct packed {
		logic carry;
		logic half_carry;
		logic zero;
	} aai_flags_type;

	typedef struct packed {
		logic [DATA_W-1:0] result;
		aai_flags_type flags;
	} aai_alu_out_type;

	typedef struct packed {
		aai_phase_type phase;
		aai_op_type op;
		logic dest_reg;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] operand;
		aai_alu_out_type alu;
		logic [DATA_W-1:0] acc;
		aai_flags_type flags;
		logic mem_we;
		logic [ADDR_W-1:0] mem_addr;
		logic [DATA_W-1:0] mem_data;
		logic done;
	} aai_state_type;
endpackage : aai_pkg

// file: core/aai_alu.sv
// ALU slice: add and AND with carry, half carry and zero
`timescale 1ns/1ps
module aai_alu (
	input wire logic [aai_pkg::DATA_W-1:0] acc_in,
	input wire logic [aai_pkg::DATA_W-1:0] operand_in,
	input wire logic is_add_in,
	input wire aai_pkg::aai_flags_type flags_in,
	output aai_pkg::aai_alu_out_type alu_out
);
	logic [aai_pkg::DATA_W:0] sum;
	logic [aai_pkg::HALF_W:0] low_sum;
	always_comb begin
		sum = {1'b0, acc_in} + {1'b0, operand_in};
		low_sum = {1'b0, acc_in[aai_pkg::HALF_W-1:0]} + {1'b0, operand_in[aai_pkg::HALF_W-1:0]};
		alu_out.flags = flags_in;
		if (is_add_in) begin
			alu_out.result = sum[aai_pkg::DATA_W-1:0];
			alu_out.flags.carry = sum[aai_pkg::DATA_W];
			alu_out.flags.half_carry = low_sum[aai_pkg::HALF_W];
		end else begin
			// AND keeps carry and half carry untouched
			alu_out.result = acc_in & operand_in;
		end
		alu_out.flags.zero = (alu_out.result == aai_pkg::ZERO_BYTE);
	end
endmodule : aai_alu

// file: test/aai_bench.sv
// Self-checking bench for the four-phase add/AND execution unit
`timescale 1ns/1ps
module add_and_alu_instructions_bench;
	logic clk_in;
	logic reset_n_in;
	logic [aai_pkg::WORD_W-1:0] instr_in;
	logic [aai_pkg::ADDR_W-1:0] port_addr_in;
	logic [aai_pkg::DATA_W-1:0] port_pins_in;
	logic [aai_pkg::DATA_W-1:0] acc_out;
	aai_pkg::aai_flags_type flags_out;
	aai_pkg::aai_phase_type phase_out;
	logic done_out;
	logic mem_we_out;
	logic [aai_pkg::ADDR_W-1:0] mem_addr_out;
	logic [aai_pkg::DATA_W-1:0] mem_data_out;
	int error_cnt;
	int checks_done;
	// Reference accumulator and flags {carry, half carry, zero}
	logic [7:0] m_acc;
	logic [2:0] m_flg;

	aai_core dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .instr_in(instr_in),
		.port_addr_in(port_addr_in), .port_pins_in(port_pins_in), .acc_out(acc_out),
		.flags_out(flags_out), .phase_out(phase_out), .done_out(done_out),
		.mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out), .mem_data_out(mem_data_out));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done

	// One instruction, then a nop slot so the word is never taken twice
	task automatic do_op(input logic [13:0] w, input logic [7:0] opnd);
		logic [8:0] sum;
		logic is_add;
		logic known;
		logic to_reg;
		logic [7:0] res;
		is_add = (w[13:9] == 5'h1f) || (w[13:8] == 6'h07);
		known = is_add || (w[13:8] == 6'h39) || (w[13:8] == 6'h05);
		to_reg = (w[13:12] == 2'h0) && w[7];
		sum = {1'b0, m_acc} + {1'b0, opnd};
		res = is_add ? sum[7:0] : (m_acc & opnd);
		if (known) begin
			m_flg[0] = (res == 8'h00);
			if (is_add) begin
				m_flg[2:1] = {sum[8], ({1'b0, m_acc[3:0]} + {1'b0, opnd[3:0]}) > 5'h0f};
			end
			if (!to_reg) begin
				m_acc = res;
			end
		end
		instr_in <= w;
		for (int i = 1; i <= 4; i++) begin
			@(posedge clk_in);
			if (i == 4) begin
				instr_in <= aai_pkg::ZERO_WORD;
			end
			#1;
			chk("phase", 8'(i % 4), 8'(phase_out));
		end
		chk("acc", m_acc, acc_out);
		chk("flags", {5'h00, m_flg}, {5'h00, flags_out});
		chk("done", {7'h00, known}, {7'h00, done_out});
		chk("mem_we", {7'h00, known && to_reg}, {7'h00, mem_we_out});
		if (known && to_reg) begin
			chk("mem_addr", {1'b0, w[6:0]}, {1'b0, mem_addr_out});
			chk("mem_data", res, mem_data_out);
		end
		repeat (4) @(posedge clk_in);
	endtask : do_op

	////////////////////////////////////////////////////////////////////////////////
	task automatic lit_ops;
		do_op(14'h3e15, 8'h15);
		do_op(14'h3feb, 8'heb);
		do_op(14'h39ff, 8'hff);
		do_op(14'h3ea3, 8'ha3);
		do_op(14'h395f, 8'h5f);
	endtask : lit_ops

	// Port at 127; pins differ from what gets written there
	task automatic reg_ops;
		port_pins_in <= 8'hc2;
		repeat (4) @(posedge clk_in);
		do_op(14'h077f, 8'hc2);
		do_op(14'h05ff, 8'hc2);
		do_op(14'h07ff, 8'hc2);
		port_addr_in <= 7'h00;
		repeat (4) @(posedge clk_in);
		do_op(14'h077f, 8'h87);
	endtask : reg_ops

	task automatic refused;
		do_op(14'h3812, 8'h12);
		do_op(14'h0285, 8'h00);
	endtask : refused

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	initial begin
		error_cnt = 0;
		checks_done = 0;
		m_acc = 8'h00;
		m_flg = 3'h0;
		reset_n_in = 1'b0;
		instr_in = aai_pkg::ZERO_WORD;
		port_addr_in = 7'h7f;
		port_pins_in = 8'h00;
		repeat (16) @(posedge clk_in);
		chk("reset acc", 8'h00, acc_out);
		chk("reset phase", 8'h00, 8'(phase_out));
		reset_n_in <= 1'b1;
		lit_ops();
		reg_ops();
		refused();
		test_done();
	end

	// Whole run is near 112 cycles
	initial begin
		repeat (2000) @(posedge clk_in);
		error_cnt++;
		test_done();
	end
endmodule : add_and_alu_instructions_bench
